// [verilog/u_link_defines.vh]
// constants for the u-interface link supervision block
`ifndef U_LINK_DEFINES_VH
`define U_LINK_DEFINES_VH
// ************************************************************
// timing
// ************************************************************
`define CLK_MHZ 32'd125
`define SYNC_LOSS_MS 32'd480
`define ACT_TIMEOUT_S 32'd15
`define DEA_SUPERFRAMES 2'd3
// ************************************************************
// register word offsets, word index on adr[4:2]
// ************************************************************
`define REG_STATUS 3'h0
`define REG_CONTROL 3'h1
`define REG_PORT_OPT 3'h2
`define REG_TX_M4 3'h3
`define REG_RX_M4 3'h4
`define REG_FRAME_STATE 3'h5
`define REG_TIMER_OPT 3'h6
`define REG_IRQ_EN 3'h7
// ************************************************************
// status codes and bits
// ************************************************************
`define STS_IDLE 4'h0
`define STS_ACT 4'h1
`define STS_ERROR 4'h4
`define STS_SYNC_LOST 4'h8
`define STS_NO_TRANSP 4'ha
`define STS_ACTIVE 4'hb
`define STS_ERR_BIT 2
// ************************************************************
// control fields
// ************************************************************
`define CTL_ACT_REQ 3
`define CTL_DEA_REQ 2
`define CTL_UPD_DIS 1
`define CTL_CUST_EN 0
`define OPT_SWAP 0
`define OPT_VERIFIED 1
`define OPT_NT_ROLE 2
`define TMR_ACT_DIS 0
`define M4_DEA_BIT 6
`define FRAME_HOLD_CODE 4'ha
`define FRAME_RUN_CODE 4'h0
`define IRQ_SYNC_LOST 0
`define IRQ_ERROR 1
`define IRQ_ACTIVE 2
`define IRQ_NO_TRANSP 3
`define RST_TX_M4 8'hff
`endif

// [verilog/u_timeout.v]
// cycle timeout counter, restarts whenever run drops
`timescale 1ns/1ps
module u_timeout #(
  parameter [31:0] LIMIT = 32'd16
) (
  input wire clk_i,
  input wire rst_i,
  input wire run_i,
  output reg expired_o
);
  reg [31:0] cnt_ff;
  // count while running, one pulse at the limit
  always @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      cnt_ff <= 32'h0;
      expired_o <= 1'b0;
    end else begin
      expired_o <= (cnt_ff == LIMIT - 32'd1);
      if (cnt_ff != LIMIT)
        cnt_ff <= cnt_ff + 32'd1;
    end
  end
endmodule

// [verilog/u_chan_map.v]
// b1/b2/d channel gate and swap stage, registered
`timescale 1ns/1ps
module u_chan_map #(
  parameter [7:0] FILL = 8'hff
) (
  input wire clk_i,
  input wire rst_i,
  input wire en_i,
  input wire swap_i,
  input wire [7:0] b1_i,
  input wire [7:0] b2_i,
  input wire [1:0] d_i,
  output reg [7:0] b1_o,
  output reg [7:0] b2_o,
  output reg [1:0] d_o
);
  // idle fill while disabled, optional b1/b2 exchange
  always @(posedge clk_i) begin
    if (rst_i || !en_i) begin
      b1_o <= FILL;
      b2_o <= FILL;
      d_o <= FILL[1:0];
    end else begin
      b1_o <= swap_i ? b2_i : b1_i;
      b2_o <= swap_i ? b1_i : b2_i;
      d_o <= d_i;
    end
  end
endmodule

// [verilog/u_link_status_and_deactivation.v]
// link status supervision, deactivation control and channel gating
//
// Functional notes
// [RQ1] link-up bit set only while loop is fully active in either role
// [RQ2] fully active line shows sync and link-up bits both at one
// [RQ3] loss of superframe sync gives status 8 and enabled interrupt
// [RQ4] sync lost over 480 ms deactivates, status 4, enabled interrupt
// [RQ5] sync back within 480 ms returns status B, customer enable kept
// [RQ6] high error rate drops transparency, status A without time limit
// [RQ7] controller sets tx act bit and customer enable after lt activation
// [RQ8] nt deactivates warm if request preceded line drop, else cold with error
// [RQ9] nt controller never starts deactivation, answers received dea zero
// [RQ10] verified mode on nt sets deactivation request automatically
// [RQ11] lt controller sends dea zero three superframes then requests down
// [RQ12] lt deactivation sends exactly three superframes with dea zero
// [RQ13] customer enable is zero after reset
// [RQ14] without verified mode software sets customer enable at status B
// [RQ15] after activation b1, b2, d pass to system port in order
// [RQ16] swap bit exchanges b1 and b2 timeslots on system port
// [RQ17] rx maintenance bits readable after link-up; enable gates 2b+d only
// [RQ18] frame state field reads framer state; A holds in sn2, 0 releases
// [RQ19] repeater software polls frame state each millisecond before hold
// [RQ20] timer disable bit stops the 15 second activation timeout
// [RQ21] activation not done in 15 s aborts with error, status bits cleared
// [RQ22] full duplex sets status bits 3, 1, 0 together, code B
// [RQ23] data transparent when verified act or customer enable is one
// [RQ24] status change interrupts only when matching enable bit is one
`timescale 1ns/1ps
`include "u_link_defines.vh"
module u_link_status_and_deactivation #(
  parameter [31:0] SYNC_LOSS_CYC = `SYNC_LOSS_MS * 32'd1000 * `CLK_MHZ,
  parameter [31:0] ACT_TIMEOUT_CYC = `ACT_TIMEOUT_S * 32'd1000000 * `CLK_MHZ
) (
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [4:2] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  // transceiver side
  input wire wake_tone_i,
  input wire full_duplex_i,
  input wire sf_sync_i,
  input wire err_high_i,
  input wire far_deact_i,
  input wire superframe_i,
  input wire rx_act_ver_i,
  input wire rx_dea_ver_i,
  input wire [7:0] rx_m4_i,
  input wire [3:0] framer_state_i,
  output reg [3:0] line_status_nibble_o,
  output reg link_up_o,
  output reg act_start_o,
  output reg line_deact_o,
  output reg warm_start_o,
  output reg transparent_o,
  output reg framer_hold_o,
  output reg [7:0] tx_m4_byte_o,
  output reg irq_o,
  // line to system port
  input wire [7:0] line_b1_i,
  input wire [7:0] line_b2_i,
  input wire [1:0] line_d_i,
  output wire [7:0] tdm_b1_o,
  output wire [7:0] tdm_b2_o,
  output wire [1:0] tdm_d_o,
  // system port to line
  input wire [7:0] tdm_b1_i,
  input wire [7:0] tdm_b2_i,
  input wire [1:0] tdm_d_i,
  output wire [7:0] line_b1_o,
  output wire [7:0] line_b2_o,
  output wire [1:0] line_d_o
);
  // ************************************************************
  // states
  // ************************************************************
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_ACT = 6'h02;
  localparam [5:0] ST_UP = 6'h04;
  localparam [5:0] ST_LOSS = 6'h08;
  localparam [5:0] ST_NOTR = 6'h10;
  localparam [5:0] ST_DEA = 6'h20;

  reg [5:0] state_ff, nxt_state;
  reg [3:0] line_control_nibble_ff;
  reg [2:0] port_option_nibble_ff;
  reg [7:0] tx_m4_byte_ff;
  reg [7:0] rx_m4_ff;
  reg timer_option_byte_ff;
  reg [3:0] irq_en_ff;
  reg error_ff, nxt_error;
  reg [1:0] sf_cnt_ff;
  reg [3:0] nxt_status;
  reg deact_now, clr_act_req, clr_dea_req, set_dea_req;
  wire sync_expired, act_expired;
  wire wb_req = cyc_i & stb_i & ~ack_o;
  wire wr_lo = wb_req & we_i & sel_i[0];
  wire nt_role = port_option_nibble_ff[`OPT_NT_ROLE];
  wire verified = port_option_nibble_ff[`OPT_VERIFIED];
  wire link_active = (state_ff == ST_UP) | (state_ff == ST_DEA);

  // ************************************************************
  // timers
  // ************************************************************
  // 480 ms sync loss deadline runs only while sync is lost
  u_timeout #(.LIMIT(SYNC_LOSS_CYC)) u_sync_tmr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(state_ff == ST_LOSS),
    .expired_o(sync_expired)
  );

  // 15 s activation deadline, stopped by the disable bit
  u_timeout #(.LIMIT(ACT_TIMEOUT_CYC)) u_act_tmr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i((state_ff == ST_ACT) & ~timer_option_byte_ff), // [RQ20]
    .expired_o(act_expired)
  );

  // ************************************************************
  // link state machine
  // ************************************************************
  // next state, error flag and request side effects
  always @* begin
    nxt_state = state_ff;
    nxt_error = error_ff;
    deact_now = 1'b0;
    clr_act_req = 1'b0;
    clr_dea_req = 1'b0;
    set_dea_req = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (line_control_nibble_ff[`CTL_ACT_REQ] | wake_tone_i) begin
          nxt_state = ST_ACT;
          nxt_error = 1'b0;
          clr_act_req = 1'b1;
        end
      end
      ST_ACT: begin
        if (full_duplex_i) begin
          nxt_state = ST_UP; // [RQ22]
        end else if (act_expired) begin
          nxt_state = ST_IDLE; // [RQ21]
          nxt_error = 1'b1;
        end
      end
      ST_UP, ST_LOSS, ST_NOTR: begin
        if (state_ff == ST_LOSS && sync_expired) begin
          nxt_state = ST_IDLE; // [RQ4]
          nxt_error = 1'b1;
          deact_now = 1'b1;
        end else if (nt_role && far_deact_i) begin
          nxt_state = ST_IDLE; // [RQ8]
          nxt_error = ~line_control_nibble_ff[`CTL_DEA_REQ];
          clr_dea_req = 1'b1;
          deact_now = 1'b1;
        end else if (!nt_role && line_control_nibble_ff[`CTL_DEA_REQ]) begin
          nxt_state = ST_DEA; // [RQ12]
          clr_dea_req = 1'b1;
        end else if (!sf_sync_i) begin
          nxt_state = ST_LOSS; // [RQ3]
        end else if (err_high_i) begin
          nxt_state = ST_NOTR; // [RQ6]
        end else begin
          nxt_state = ST_UP; // [RQ5]
        end
        if (nt_role && verified && !rx_dea_ver_i && state_ff == ST_UP)
          set_dea_req = 1'b1; // [RQ10]
      end
      ST_DEA: begin
        if (superframe_i && sf_cnt_ff == `DEA_SUPERFRAMES - 2'd1) begin
          nxt_state = ST_IDLE; // [RQ12]
          deact_now = 1'b1;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // status code from the next state
  always @* begin
    case (nxt_state)
      ST_ACT: nxt_status = `STS_ACT;
      ST_UP, ST_DEA: nxt_status = `STS_ACTIVE; // [RQ1] [RQ2] [RQ22]
      ST_LOSS: nxt_status = `STS_SYNC_LOST; // [RQ3]
      ST_NOTR: nxt_status = `STS_NO_TRANSP; // [RQ6]
      default: nxt_status = nxt_error ? `STS_ERROR : `STS_IDLE; // [RQ4] [RQ21]
    endcase
  end

  // state, status and line event registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
      error_ff <= 1'b0;
      sf_cnt_ff <= 2'd0;
      line_status_nibble_o <= `STS_IDLE;
      link_up_o <= 1'b0;
      act_start_o <= 1'b0;
      line_deact_o <= 1'b0;
      warm_start_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      error_ff <= nxt_error;
      line_status_nibble_o <= nxt_status;
      link_up_o <= nxt_status[3] & nxt_status[0]; // [RQ1]
      act_start_o <= (state_ff == ST_IDLE) & (nxt_state == ST_ACT);
      line_deact_o <= deact_now;
      // warm start kept until the next activation begins
      if (deact_now)
        warm_start_o <= ~nxt_error; // [RQ8]
      else if (nxt_state == ST_ACT)
        warm_start_o <= 1'b0;
      // three superframe count up from zero toward deactivation
      if (state_ff != ST_DEA)
        sf_cnt_ff <= 2'd0;
      else if (superframe_i)
        sf_cnt_ff <= sf_cnt_ff + 2'd1; // [RQ12]
      // one pulse per status change whose enable is set
      irq_o <= (nxt_status != line_status_nibble_o) & (
        (nxt_status == `STS_SYNC_LOST & irq_en_ff[`IRQ_SYNC_LOST]) |
        (nxt_status == `STS_ERROR & irq_en_ff[`IRQ_ERROR]) |
        (nxt_status == `STS_ACTIVE & irq_en_ff[`IRQ_ACTIVE]) |
        (nxt_status == `STS_NO_TRANSP & irq_en_ff[`IRQ_NO_TRANSP])); // [RQ24]
    end
  end

  // ************************************************************
  // register file
  // ************************************************************
  // software writes, hardware set and clear of request bits
  always @(posedge clk_i) begin
    if (rst_i) begin
      line_control_nibble_ff <= 4'h0; // [RQ13]
      port_option_nibble_ff <= 3'h0;
      tx_m4_byte_ff <= `RST_TX_M4;
      timer_option_byte_ff <= 1'b0;
      irq_en_ff <= 4'h0;
      framer_hold_o <= 1'b0;
    end else begin
      if (wr_lo) begin
        case (adr_i)
          `REG_CONTROL: line_control_nibble_ff <= dat_i[3:0];
          `REG_PORT_OPT: port_option_nibble_ff <= dat_i[2:0];
          `REG_TX_M4: tx_m4_byte_ff <= dat_i[7:0];
          `REG_TIMER_OPT: timer_option_byte_ff <= dat_i[`TMR_ACT_DIS]; // [RQ20]
          `REG_IRQ_EN: irq_en_ff <= dat_i[3:0];
          `REG_FRAME_STATE: begin
            if (dat_i[7:4] == `FRAME_HOLD_CODE)
              framer_hold_o <= 1'b1; // [RQ18]
            else if (dat_i[7:4] == `FRAME_RUN_CODE)
              framer_hold_o <= 1'b0; // [RQ18]
          end
          default: begin
          end
        endcase
      end
      // hardware set and clear win over a write in the same cycle
      if (clr_act_req)
        line_control_nibble_ff[`CTL_ACT_REQ] <= 1'b0;
      if (set_dea_req)
        line_control_nibble_ff[`CTL_DEA_REQ] <= 1'b1; // [RQ10]
      else if (clr_dea_req)
        line_control_nibble_ff[`CTL_DEA_REQ] <= 1'b0;
    end
  end

  // m4 bytes: tx frozen by update disable, rx captured after link-up
  always @(posedge clk_i) begin
    if (rst_i) begin
      tx_m4_byte_o <= `RST_TX_M4;
      rx_m4_ff <= 8'h0;
      transparent_o <= 1'b0;
    end else begin
      if (!line_control_nibble_ff[`CTL_UPD_DIS])
        tx_m4_byte_o <= tx_m4_byte_ff; // [RQ12]
      if (link_active & sf_sync_i)
        rx_m4_ff <= rx_m4_i; // [RQ17]
      transparent_o <= link_active & ((verified & rx_act_ver_i) |
        line_control_nibble_ff[`CTL_CUST_EN]); // [RQ23] [RQ5]
    end
  end

  // wishbone classic answer, one wait state, zero for unmapped
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end else begin
      ack_o <= wb_req;
      if (wb_req && !we_i) begin
        case (adr_i)
          `REG_STATUS: dat_o <= {28'h0, line_status_nibble_o};
          `REG_CONTROL: dat_o <= {28'h0, line_control_nibble_ff};
          `REG_PORT_OPT: dat_o <= {29'h0, port_option_nibble_ff};
          `REG_TX_M4: dat_o <= {24'h0, tx_m4_byte_ff};
          `REG_RX_M4: dat_o <= {24'h0, rx_m4_ff}; // [RQ17]
          `REG_FRAME_STATE: dat_o <= {24'h0, framer_state_i, 3'h0, framer_hold_o}; // [RQ18]
          `REG_TIMER_OPT: dat_o <= {31'h0, timer_option_byte_ff};
          `REG_IRQ_EN: dat_o <= {28'h0, irq_en_ff};
          default: dat_o <= 32'h0;
        endcase
      end
    end
  end

  // ************************************************************
  // channel paths
  // ************************************************************
  // line to system port, enabled once the link is up
  u_chan_map #(.FILL(8'hff)) u_rx_map (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(link_up_o), // [RQ15]
    .swap_i(port_option_nibble_ff[`OPT_SWAP]), // [RQ16]
    .b1_i(line_b1_i),
    .b2_i(line_b2_i),
    .d_i(line_d_i),
    .b1_o(tdm_b1_o),
    .b2_o(tdm_b2_o),
    .d_o(tdm_d_o)
  );

  // system port to line, gated by transparency on 2b+d only
  u_chan_map #(.FILL(8'hff)) u_tx_map (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(transparent_o), // [RQ17] [RQ23]
    .swap_i(port_option_nibble_ff[`OPT_SWAP]), // [RQ16]
    .b1_i(tdm_b1_i),
    .b2_i(tdm_b2_i),
    .d_i(tdm_d_i),
    .b1_o(line_b1_o),
    .b2_o(line_b2_o),
    .d_o(line_d_o)
  );
endmodule

// [dv/u_link_checker_assertions.sv]
// assertion checker for the link supervision block
`timescale 1ns/1ps
module u_link_checker #(
  parameter [31:0] SYNC_LOSS_CYC = 32'd50
) (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire we_i,
  input wire [4:2] adr_i,
  input wire ack_o,
  input wire sf_sync_i,
  input wire err_high_i,
  input wire far_deact_i,
  input wire superframe_i,
  input wire full_duplex_i,
  input wire [3:0] line_status_nibble_o,
  input wire link_up_o,
  input wire transparent_o,
  input wire framer_hold_o,
  input wire irq_o,
  input wire [7:0] tdm_b1_o,
  input wire [7:0] line_b1_o
);
  logic [31:0] lost_ff;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // cycles spent showing the sync-lost code
  always @(posedge clk_i) begin
    if (rst_i || line_status_nibble_o != 4'h8) begin
      lost_ff <= 32'h0;
    end else begin
      lost_ff <= lost_ff + 32'h1;
    end
  end
  a_link_up_code: assert property (link_up_o == (line_status_nibble_o == 4'hb))
    else $error("bad link-up");
  a_sync_lost_code: assert property (line_status_nibble_o == 4'hb && !sf_sync_i
    && !far_deact_i && !cyc_i && !superframe_i |=> line_status_nibble_o == 4'h8)
    else $error("no sync-lost code");
  a_noise_code: assert property (line_status_nibble_o == 4'hb && sf_sync_i && err_high_i
    && !far_deact_i && !cyc_i && !superframe_i |=> line_status_nibble_o == 4'ha)
    else $error("no noise code");
  a_loss_bounded: assert property (lost_ff <= SYNC_LOSS_CYC + 32'd1)
    else $error("sync-lost code held too long");
  a_duplex_active: assert property (line_status_nibble_o == 4'h1 && full_duplex_i
    |=> line_status_nibble_o == 4'hb) else $error("no active code");
  a_irq_on_change: assert property (irq_o |->
    line_status_nibble_o != $past(line_status_nibble_o))
    else $error("irq without status change");
  a_line_fill: assert property (!transparent_o && !$past(transparent_o)
    && !$past(transparent_o, 2) |-> line_b1_o == 8'hff) else $error("line data leaks");
  a_tdm_fill: assert property (!link_up_o && !$past(link_up_o)
    && !$past(link_up_o, 2) |-> tdm_b1_o == 8'hff) else $error("port data leaks");
  a_hold_by_write: assert property ($changed(framer_hold_o) |-> ack_o && we_i
    && adr_i == 3'h5) else $error("hold changed without write");
endmodule
bind u_link_status_and_deactivation u_link_checker #(.SYNC_LOSS_CYC(SYNC_LOSS_CYC)) props (.*);

// [dv/far_peer.sv]
// far-end transceiver model feeding the line-side status inputs
`timescale 1ns/1ps
module far_peer (
  input wire clk_i,
  input wire train_i,
  input wire lose_i,
  input wire noisy_i,
  input wire drop_i,
  input wire dea_i,
  output wire full_duplex_o,
  output wire sf_sync_o,
  output wire err_high_o,
  output wire far_deact_o,
  output wire superframe_o,
  output wire rx_dea_ver_o,
  output wire [7:0] rx_m4_o,
  output wire [3:0] framer_state_o
);
  logic [3:0] sf_ff = 4'h0;
  logic [2:0] trn_ff = 3'h0;
  logic drop_ff = 1'b0;
  // superframe tick every 16 clocks, training takes seven
  always @(posedge clk_i) begin
    sf_ff <= sf_ff + 4'h1;
    trn_ff <= !train_i ? 3'h0 : (trn_ff == 3'h7 ? trn_ff : trn_ff + 3'h1);
    drop_ff <= drop_i;
  end
  // line levels; m4 byte scrambles while sync is absent
  assign full_duplex_o = trn_ff == 3'h7;
  assign sf_sync_o = full_duplex_o && !lose_i;
  assign err_high_o = noisy_i;
  assign far_deact_o = drop_i && !drop_ff;
  assign superframe_o = sf_ff == 4'hf;
  assign rx_dea_ver_o = dea_i;
  assign rx_m4_o = sf_sync_o ? {1'b1, dea_i, 6'h2a} : {sf_ff, ~sf_ff};
  assign framer_state_o = full_duplex_o ? 4'h3 : 4'h2;
endmodule

// [dv/u_link_status_and_deactivation_tb.sv]
// self-checking bench for the link supervision block
`timescale 1ns/1ps
module u_link_status_and_deactivation_tb;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
  logic [4:2] adr_i;
  logic [3:0] sel_i, framer_state_i, line_status_nibble_o;
  logic [31:0] dat_i, dat_o, q;
  logic wake_tone_i, full_duplex_i, sf_sync_i, err_high_i, far_deact_i, superframe_i;
  logic rx_act_ver_i, rx_dea_ver_i, link_up_o, act_start_o, line_deact_o, warm_start_o;
  logic transparent_o, framer_hold_o, irq_o, train, lose, noisy, drop, dea;
  logic [7:0] rx_m4_i, tx_m4_byte_o, line_b1_i, line_b2_i, tdm_b1_o, tdm_b2_o;
  logic [7:0] tdm_b1_i, tdm_b2_i, line_b1_o, line_b2_o;
  logic [1:0] line_d_i, tdm_d_o, tdm_d_i, line_d_o;
  int err_total, comparisons, irqs, cycles, sf, n;
  u_link_status_and_deactivation #(.SYNC_LOSS_CYC(32'd50), .ACT_TIMEOUT_CYC(32'd100)) uut (.*);
  far_peer peer (.clk_i, .train_i(train), .lose_i(lose), .noisy_i(noisy), .drop_i(drop),
    .dea_i(dea), .full_duplex_o(full_duplex_i), .sf_sync_o(sf_sync_i),
    .err_high_o(err_high_i), .far_deact_o(far_deact_i), .superframe_o(superframe_i),
    .rx_dea_ver_o(rx_dea_ver_i), .rx_m4_o(rx_m4_i), .framer_state_o(framer_state_i));
  // ************************************************************
  // helpers
  // ************************************************************
  task report_and_stop;
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // one classic wishbone cycle, held until ack
  task bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task rc(input logic [2:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, {24'h0, e});
  endtask
  // wait a bounded time for a status code
  task wst(input logic [3:0] c);
    int k;
    k = 0;
    while (line_status_nibble_o !== c && k < 400) begin
      @(posedge clk_i);
      k++;
    end
    chk(line_status_nibble_o, c);
  endtask
  // ************************************************************
  // clock, irq count and timeout
  // ************************************************************
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    irqs += (irq_o === 1'b1);
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      report_and_stop;
    end
  end
  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    {rst_i, sel_i, dea} = 6'h3f;
    {cyc_i, stb_i, we_i, adr_i, dat_i, wake_tone_i, rx_act_ver_i} = 0;
    {train, lose, noisy, drop} = 4'h0;
    {line_b1_i, line_b2_i, line_d_i, tdm_b1_i, tdm_b2_i, tdm_d_i} = 36'h1122_4cd12;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(3'h1, 8'h00);
    rc(3'h3, 8'hff);
    wr(3'h0, 8'h55);
    rc(3'h0, 8'h00);
    chk(line_b1_o, 8'hff);
    wr(3'h7, 8'h0f);
    wr(3'h1, 8'h08);
    wst(4'h1);
    chk(act_start_o, 1'b1);
    train <= 1'b1;
    wst(4'hb);
    repeat (3) @(posedge clk_i);
    chk({link_up_o, irqs[3:0]}, 5'h11);
    chk({tdm_b1_o, tdm_b2_o, tdm_d_o, line_b1_o}, 26'h4489ff);
    wr(3'h3, 8'hff);
    wr(3'h1, 8'h01);
    repeat (3) @(posedge clk_i);
    chk({transparent_o, line_b1_o, line_b2_o, line_d_o}, 19'h4cd12);
    wr(3'h2, 8'h01);
    repeat (3) @(posedge clk_i);
    chk({tdm_b1_o, tdm_b2_o, line_b1_o, line_b2_o}, 32'h22114433);
    wr(3'h2, 8'h00);
    rc(3'h4, 8'hea);
    lose <= 1'b1;
    wst(4'h8);
    lose <= 1'b0;
    wst(4'hb);
    repeat (3) @(posedge clk_i);
    chk({transparent_o, irqs[3:0]}, 5'h13);
    noisy <= 1'b1;
    wst(4'ha);
    repeat (80) @(posedge clk_i);
    chk({line_status_nibble_o, transparent_o}, 5'h14);
    noisy <= 1'b0;
    wst(4'hb);
    wr(3'h7, 8'h00);
    n = irqs;
    lose <= 1'b1;
    wst(4'h8);
    lose <= 1'b0;
    wst(4'hb);
    repeat (3) @(posedge clk_i);
    chk(irqs, n);
    wr(3'h7, 8'h0f);
    rc(3'h5, 8'h30);
    wr(3'h5, 8'ha0);
    chk(framer_hold_o, 1'b1);
    rc(3'h5, 8'h31);
    wr(3'h5, 8'h50);
    chk(framer_hold_o, 1'b1);
    wr(3'h5, 8'h00);
    chk(framer_hold_o, 1'b0);
    n = irqs;
    lose <= 1'b1;
    wst(4'h8);
    wst(4'h4);
    chk(line_deact_o, 1'b1);
    repeat (3) @(posedge clk_i);
    chk(link_up_o, 1'b0);
    chk(irqs, n + 2);
    {lose, train} <= 2'b00;
    wr(3'h1, 8'h08);
    train <= 1'b1;
    wst(4'hb);
    wr(3'h1, 8'h03);
    wr(3'h3, 8'hbf);
    chk(tx_m4_byte_o, 8'hff);
    wr(3'h1, 8'h05);
    sf = 0;
    for (int i = 0; i < 200 && line_deact_o !== 1'b1; i++) begin
      @(posedge clk_i);
      sf += (superframe_i === 1'b1 && line_deact_o !== 1'b1);
    end
    chk({tx_m4_byte_o, sf[3:0]}, 12'hbf3);
    wst(4'h0);
    train <= 1'b0;
    wr(3'h6, 8'h01);
    wr(3'h1, 8'h08);
    wst(4'h1);
    repeat (150) @(posedge clk_i);
    chk(line_status_nibble_o, 4'h1);
    wr(3'h6, 8'h00);
    wst(4'h4);
    rx_act_ver_i <= 1'b1;
    for (int m = 0; m < 3; m++) begin
      wr(3'h2, m == 2 ? 8'h06 : 8'h04);
      if (m == 1) wake_tone_i <= 1'b1;
      else wr(3'h1, 8'h08);
      train <= 1'b1;
      wst(4'hb);
      wake_tone_i <= 1'b0;
      dea <= 1'b0;
      if (m == 0) wr(3'h1, 8'h04);
      repeat (3) @(posedge clk_i);
      chk(transparent_o, m == 2);
      if (m == 2) rc(3'h1, 8'h04);
      drop <= 1'b1;
      wst(m == 1 ? 4'h4 : 4'h0);
      chk(warm_start_o, m != 1);
      {drop, train, dea} <= 3'b001;
    end
    report_and_stop;
  end
endmodule
